/* File: common/uvs_pkg.sv */
package uvs_pkg;
  // ==========================================================
  // Structure
  localparam int NUM_INST = 4;
  localparam int REC_DEPTH = 12;
  localparam int OPW = 19;
  localparam int RLW = 15;
  localparam int VW = 16;
  localparam int TSW = 32;
  localparam int SGW = 3;
  localparam int FTW = 2;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_MS = 5;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int REL_DEFAULT_MS = 60;
  localparam int OPD_DEFAULT_MS = 40;
  localparam int PRE_TRIG_MS = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam logic [RLW-1:0] REL_DEFAULT_TICKS = RLW'(REL_DEFAULT_MS / TICK_PERIOD_MS);
  localparam logic [OPW-1:0] OPD_DEFAULT_TICKS = OPW'(OPD_DEFAULT_MS / TICK_PERIOD_MS);
  localparam int PRE_TRIG_TICKS = PRE_TRIG_MS / TICK_PERIOD_MS;
  localparam int PRE_FAULT_TICKS = PRE_FAULT_MS / TICK_PERIOD_MS;
  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CFG_BASE = 8'h10;
  localparam logic [7:0] REG_REL_BASE = 8'h20;
  localparam logic [7:0] REG_OPD_BASE = 8'h30;
  localparam logic [7:0] REG_STAT_BASE = 8'h40;
  localparam logic [7:0] REG_IRQ_STAT = 8'h50;
  localparam logic [7:0] REG_IRQ_MASK = 8'h54;
  localparam logic [7:0] REG_REC_SEL = 8'h58;
  localparam logic [7:0] REG_REC_INFO = 8'h5C;
  localparam logic [7:0] REG_REC_STAMP = 8'h60;
  localparam logic [7:0] REG_REC_ID = 8'h64;
  localparam logic [7:0] REG_REC_VOLT = 8'h68;
  localparam logic [7:0] REG_REC_PRE = 8'h6C;
  localparam logic [7:0] REG_REC_REMAIN = 8'h70;
  localparam int CFG_DLY_REL = 0;
  localparam int CFG_RST_AFTER = 1;
  localparam int CFG_CONT = 2;
  localparam int CFG_EVT_ON = 3;
  localparam int CFG_EVT_OFF = 4;
  localparam int CFGW = 5;
  localparam logic [CFGW-1:0] CFG_RESET = 5'h1B;
  localparam int IRQW = 3 * NUM_INST;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {KIND_BLOCK, KIND_START, KIND_TRIP, KIND_LOWV} uvs_kind_t;
  typedef struct packed {
    logic [1:0] inst;
    uvs_kind_t kind;
    logic rising;
    logic [TSW-1:0] stamp;
    logic [VW-1:0] v_now;
    logic [VW-1:0] v_pre20;
    logic [FTW-1:0] fault;
    logic [SGW-1:0] setting_group_index;
  } uvs_event_t;
  typedef struct packed {
    uvs_kind_t kind;
    logic [TSW-1:0] stamp;
    logic [FTW-1:0] fault;
    logic [VW-1:0] v_pre20;
    logic [VW-1:0] v_now;
    logic [VW-1:0] v_pre200;
    logic [OPW-1:0] remain;
    logic [SGW-1:0] setting_group_index;
  } uvs_rec_t;
endpackage

/* File: verilog/uvs_stage_events.sv */
// Notes on behaviour
// - Delayed release holds start for the release delay after pick-up drops before trip.
// - Release mode picks instant or delayed start clearing; delayed is default.
// - Timer reset after release clears count at expiry, else on drop-out.
// - Continue timing keeps the count advancing through release; off by default; the code applies it only when timer reset after release is set.
// - No trip during release unless pick-up returns before release ends.
// - Release delay defaults to 60 ms; count held during release by default.
// - Rising and falling events for start, trip, blocked; per-stage storage select.
// - Four independent instances, each with its own events incl. low-voltage block.
// - Every event carries a timestamp and captured measurement values.
// - Twelve-entry rolling record per instance, written on rising start, trip, blocked.
// - Entry holds time, event, fault type, three voltages, remaining time, group.
// - Blocking at pick-up raises blocked; blocking an active start releases it.
// - Below the low-voltage block level tripping is suppressed until pick-up clears.
`timescale 1ns/1ns
`default_nettype none
module uvs_stage_events
  import uvs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int HIST_DEPTH = PRE_FAULT_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pick-up comparator and blocking matrix
  input wire logic [NUM_INST-1:0] pickup,
  input wire logic [NUM_INST-1:0] block_in,
  input wire logic [NUM_INST-1:0] low_voltage,
  // Process data
  input wire logic [VW-1:0] volt_in,
  input wire logic [FTW-1:0] fault_type,
  input wire logic [SGW-1:0] setting_group_index,
  input wire logic [TSW-1:0] time_stamp,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Stage outputs
  output logic [NUM_INST-1:0] start_out,
  output logic [NUM_INST-1:0] trip_out,
  output logic [NUM_INST-1:0] blocked_out,
  output logic [NUM_INST-1:0] low_voltage_event_prefix_block,
  // Event stream and interrupt
  output logic evt_valid,
  output uvs_event_t evt,
  output logic irq
);
  // ==========================================================
  // Program tick
  localparam int TCW = $clog2(TICK_CYC);
  localparam int HPW = $clog2(HIST_DEPTH);
  logic [TCW-1:0] tick_cnt;
  logic tick;
  logic tick_d;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TCW'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == TCW'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) tick_d <= 1'b0;
    else tick_d <= tick;
  end
  // ==========================================================
  // Settings
  logic [CFGW-1:0] cfg [NUM_INST];
  logic [RLW-1:0] rel_dly [NUM_INST];
  logic [OPW-1:0] op_dly [NUM_INST];
  logic [OPW-1:0] remain [NUM_INST];
  logic [1:0] reg_inst;
  assign reg_inst = addr[3:2];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_INST; k++) begin
        cfg[k] <= CFG_RESET;
        rel_dly[k] <= REL_DEFAULT_TICKS;
        op_dly[k] <= OPD_DEFAULT_TICKS;
      end
    end else if (wr) begin
      if ((addr & 8'hF0) == REG_CFG_BASE) cfg[reg_inst] <= wdata[CFGW-1:0];
      if ((addr & 8'hF0) == REG_REL_BASE) rel_dly[reg_inst] <= wdata[RLW-1:0];
      if ((addr & 8'hF0) == REG_OPD_BASE) op_dly[reg_inst] <= wdata[OPW-1:0];
    end
  end
  // ==========================================================
  // Stage instances
  logic [NUM_INST*4-1:0] cur;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INST; gi++) begin : g_inst
      logic start, trip, blocked, lowv, rel;
      logic [OPW-1:0] op_cnt;
      logic [RLW-1:0] rel_cnt;
      logic eff, lowv_now, dly_rel, rst_after, cont;
      logic [OPW-1:0] next_op;
      assign eff = pickup[gi] & ~block_in[gi];
      assign lowv_now = lowv | (low_voltage[gi] & pickup[gi]);
      assign dly_rel = cfg[gi][CFG_DLY_REL];
      assign rst_after = cfg[gi][CFG_RST_AFTER];
      assign cont = cfg[gi][CFG_CONT];
      assign next_op = (op_cnt < op_dly[gi]) ? op_cnt + 1'b1 : op_cnt;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          blocked <= 1'b0;
          lowv <= 1'b0;
        end else if (tick) begin
          blocked <= pickup[gi] & block_in[gi];
          lowv <= lowv_now & pickup[gi];
        end
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          start <= 1'b0;
          trip <= 1'b0;
          rel <= 1'b0;
          op_cnt <= '0;
          rel_cnt <= '0;
        end else if (tick) begin
          if (eff) begin
            start <= 1'b1;
            rel <= 1'b0;
            rel_cnt <= '0;
            op_cnt <= next_op;
            if (op_cnt >= op_dly[gi] && !lowv_now) trip <= 1'b1;
          end else if (trip) begin
            start <= 1'b0;
            trip <= 1'b0;
            rel <= 1'b0;
            op_cnt <= '0;
            rel_cnt <= '0;
          end else if (start || rel) begin
            if (rel_cnt >= rel_dly[gi]) begin
              start <= 1'b0;
              rel <= 1'b0;
              rel_cnt <= '0;
              op_cnt <= '0;
            end else begin
              rel <= 1'b1;
              rel_cnt <= rel_cnt + 1'b1;
              start <= dly_rel;
              if (!rst_after) op_cnt <= '0;
              else if (cont) op_cnt <= next_op;
            end
          end
        end
      end
      assign cur[gi*4 +: 4] = {lowv, trip, start, blocked};
      assign remain[gi] = (op_cnt < op_dly[gi]) ? op_dly[gi] - op_cnt : '0;
      assign start_out[gi] = start;
      assign trip_out[gi] = trip;
      assign blocked_out[gi] = blocked;
      assign low_voltage_event_prefix_block[gi] = lowv;

      a_release_hold: assert property (@(posedge clk) disable iff (!rst_n)
        tick && start && !eff && !trip && dly_rel && rel_cnt < rel_dly[gi] |=> start)
        else $error("start dropped inside release delay");
      a_instant_release: assert property (@(posedge clk) disable iff (!rst_n)
        tick && start && !rel && !eff && !trip && !dly_rel |=> !start)
        else $error("start not cleared at once");
      a_timer_clear_direct: assert property (@(posedge clk) disable iff (!rst_n)
        tick && (start || rel) && !eff && !trip && !rst_after |=> op_cnt == '0)
        else $error("operating count not cleared on drop-out");
      a_cont_timing: assert property (@(posedge clk) disable iff (!rst_n)
        tick && rel && !eff && !trip && cont && rst_after && rel_cnt < rel_dly[gi]
        && op_cnt < op_dly[gi] |=> op_cnt == $past(op_cnt) + 1'b1)
        else $error("operating count stalled during release");
      a_no_trip_release: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !eff && !trip |=> !trip)
        else $error("trip without pick-up");
      a_blocked_status: assert property (@(posedge clk) disable iff (!rst_n)
        tick && pickup[gi] && block_in[gi] && !start |=> blocked && !start)
        else $error("blocked pick-up not reported");
      a_lowv_no_trip: assert property (@(posedge clk) disable iff (!rst_n)
        tick && lowv && !trip |=> !trip)
        else $error("trip under low-voltage block");
    end
  endgenerate
  // ==========================================================
  // Voltage history and snapshot
  logic [VW-1:0] hist [HIST_DEPTH];
  logic [HPW-1:0] hist_ptr;
  logic [VW-1:0] snap_now, snap_pre20, snap_pre200;
  logic [TSW-1:0] snap_stamp;
  logic [FTW-1:0] snap_fault;
  logic [SGW-1:0] snap_group;
  function automatic logic [HPW-1:0] hist_back(input logic [HPW-1:0] p, input int back);
    int v;
    v = (int'(p) + HIST_DEPTH - back) % HIST_DEPTH;
    return HPW'(v);
  endfunction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hist_ptr <= '0;
    end else if (tick) begin
      hist[hist_ptr] <= volt_in;
      hist_ptr <= (hist_ptr == HPW'(HIST_DEPTH - 1)) ? '0 : hist_ptr + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_now <= '0;
      snap_pre20 <= '0;
      snap_pre200 <= '0;
      snap_stamp <= '0;
      snap_fault <= '0;
      snap_group <= '0;
    end else if (tick) begin
      snap_now <= volt_in;
      snap_pre20 <= hist[hist_back(hist_ptr, PRE_TRIG_TICKS)];
      snap_pre200 <= hist[hist_back(hist_ptr, HIST_DEPTH)];
      snap_stamp <= time_stamp;
      snap_fault <= fault_type;
      snap_group <= setting_group_index;
    end
  end
  // ==========================================================
  // Change detection and ordered scan
  logic [NUM_INST*4-1:0] prev, chg;
  logic scanning;
  logic [3:0] scan_idx;
  logic hit, rising, store;
  logic [1:0] s_inst;
  uvs_kind_t s_kind;
  assign s_inst = scan_idx[3:2];
  assign s_kind = uvs_kind_t'(scan_idx[1:0]);
  assign hit = scanning & chg[scan_idx];
  assign rising = cur[scan_idx];
  assign store = rising ? cfg[s_inst][CFG_EVT_ON] : cfg[s_inst][CFG_EVT_OFF];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev <= '0;
      chg <= '0;
    end else if (tick_d) begin
      chg <= cur ^ prev;
      prev <= cur;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scanning <= 1'b0;
      scan_idx <= '0;
    end else if (tick_d) begin
      scanning <= 1'b1;
      scan_idx <= '0;
    end else if (scanning) begin
      scan_idx <= scan_idx + 1'b1;
      if (scan_idx == 4'hF) scanning <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_valid <= 1'b0;
      evt <= '0;
    end else begin
      evt_valid <= hit & store;
      if (hit) begin
        evt <= '{inst: s_inst, kind: s_kind, rising: rising, stamp: snap_stamp,
                 v_now: snap_now, v_pre20: snap_pre20, fault: snap_fault,
                 setting_group_index: snap_group};
      end
    end
  end
  a_scan_runs: assert property (@(posedge clk) disable iff (!rst_n)
    tick_d |=> scanning [*8])
    else $error("event scan cut short");
  a_event_stamp: assert property (@(posedge clk) disable iff (!rst_n)
    evt_valid |-> evt.stamp == snap_stamp && evt.v_now == snap_now)
    else $error("event lacks its snapshot");
  // ==========================================================
  // Fault record
  logic [5:0] rec_addr_w, rec_addr_r;
  uvs_rec_t rec_mem [NUM_INST*REC_DEPTH];
  logic [3:0] rec_wp [NUM_INST];
  logic [3:0] rec_cnt [NUM_INST];
  logic rec_we;
  logic [5:0] rec_sel;
  uvs_rec_t rec_rd;
  assign rec_we = hit & rising & (s_kind != KIND_LOWV);
  assign rec_addr_w = 6'(s_inst * REC_DEPTH) + 6'(rec_wp[s_inst]);
  assign rec_addr_r = 6'(rec_sel[5:4] * REC_DEPTH) + 6'(rec_sel[3:0]);
  assign rec_rd = (rec_sel[3:0] < 4'(REC_DEPTH)) ? rec_mem[rec_addr_r] : '0;
  always_ff @(posedge clk) begin
    if (rec_we) begin
      rec_mem[rec_addr_w] <= '{kind: s_kind, stamp: snap_stamp, fault: snap_fault,
                              v_pre20: snap_pre20, v_now: snap_now, v_pre200: snap_pre200,
                              remain: remain[s_inst], setting_group_index: snap_group};
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_INST; k++) begin
        rec_wp[k] <= '0;
        rec_cnt[k] <= '0;
      end
    end else if (rec_we) begin
      rec_wp[s_inst] <= (rec_wp[s_inst] == 4'(REC_DEPTH - 1)) ? '0 : rec_wp[s_inst] + 1'b1;
      if (rec_cnt[s_inst] != 4'(REC_DEPTH)) rec_cnt[s_inst] <= rec_cnt[s_inst] + 1'b1;
    end
  end
  a_rec_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    rec_we && rec_wp[s_inst] == 4'(REC_DEPTH - 1) |=> rec_wp[$past(s_inst)] == '0)
    else $error("record pointer did not wrap at twelve");

  // ==========================================================
  // Interrupts
  logic [IRQW-1:0] irq_stat, irq_mask, irq_set;
  always_comb begin
    irq_set = '0;
    if (rec_we) irq_set[s_inst * 3 + int'(s_kind)] = 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      if (wr && addr == REG_IRQ_MASK) irq_mask <= wdata[IRQW-1:0];
      if (wr && addr == REG_IRQ_STAT) irq_stat <= (irq_stat & ~wdata[IRQW-1:0]) | irq_set;
      else irq_stat <= irq_stat | irq_set;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // ==========================================================
  // Register reads
  always_ff @(posedge clk) begin
    if (!rst_n) rec_sel <= '0;
    else if (wr && addr == REG_REC_SEL) rec_sel <= wdata[5:0];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= '0;
      unique case (addr & 8'hF0)
        REG_CFG_BASE: rdata <= 32'(cfg[reg_inst]);
        REG_REL_BASE: rdata <= 32'(rel_dly[reg_inst]);
        REG_OPD_BASE: rdata <= 32'(op_dly[reg_inst]);
        REG_STAT_BASE: rdata <= {9'h000, remain[reg_inst], cur[reg_inst*4 +: 4]};
        default: begin
          unique case (addr)
            REG_IRQ_STAT: rdata <= 32'(irq_stat);
            REG_IRQ_MASK: rdata <= 32'(irq_mask);
            REG_REC_SEL: rdata <= 32'(rec_sel);
            REG_REC_INFO: rdata <= {24'h000000, rec_cnt[rec_sel[5:4]], rec_wp[rec_sel[5:4]]};
            REG_REC_STAMP: rdata <= rec_rd.stamp;
            REG_REC_ID: rdata <= {25'h0, rec_rd.setting_group_index, rec_rd.fault,
                                  rec_rd.kind};
            REG_REC_VOLT: rdata <= {rec_rd.v_pre20, rec_rd.v_now};
            REG_REC_PRE: rdata <= 32'(rec_rd.v_pre200);
            REG_REC_REMAIN: rdata <= 32'(rec_rd.remain);
            default: rdata <= '0;
          endcase
        end
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule
`default_nettype wire

/* File: test/uvs_pickup_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Pick-up comparator and blocking matrix stand-in
module uvs_pickup_model
  import uvs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requested levels from the bench
  input wire logic [NUM_INST-1:0] want_pick,
  input wire logic [NUM_INST-1:0] want_block,
  input wire logic [NUM_INST-1:0] want_lowv,
  // Levels toward the stage
  output logic [NUM_INST-1:0] pickup,
  output logic [NUM_INST-1:0] block_in,
  output logic [NUM_INST-1:0] low_voltage
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pickup <= '0;
      block_in <= '0;
      low_voltage <= '0;
    end else begin
      pickup <= want_pick;
      // Blocking lands one cycle after the request, long before any delay ends
      block_in <= want_block;
      low_voltage <= want_lowv;
    end
  end
endmodule
`default_nettype wire

/* File: test/undervoltage_stage_release_events_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t in %s", $time, cur); end end
module undervoltage_stage_release_events_tb_top;
  import uvs_pkg::*;
  localparam int TK = 24;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_INST-1:0] want_pick = '0;
  logic [NUM_INST-1:0] want_block = '0;
  logic [NUM_INST-1:0] want_lowv = '0;
  logic [NUM_INST-1:0] pickup, block_in, low_voltage, start_out, trip_out, blocked_out, lvb;
  logic [VW-1:0] volt_in = '0;
  logic [FTW-1:0] fault_type = '0;
  logic [SGW-1:0] sg = '0;
  logic [TSW-1:0] ts = '0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, rv;
  logic evt_valid, irq;
  uvs_event_t evt;
  uvs_event_t evq[$];
  integer seed = 32'h2bc4;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0 = 0;
  int n1, n2, n3, opd, rel, nf, i, k;
  string cur = "reset";

  uvs_pickup_model i_uvs_pickup_model (.clk(clk), .rst_n(rst_n), .want_pick(want_pick),
    .want_block(want_block), .want_lowv(want_lowv), .pickup(pickup), .block_in(block_in),
    .low_voltage(low_voltage));
  uvs_stage_events #(.TICK_CYC(TK)) i_uvs_stage_events (.clk(clk), .rst_n(rst_n),
    .pickup(pickup), .block_in(block_in), .low_voltage(low_voltage), .volt_in(volt_in),
    .fault_type(fault_type), .setting_group_index(sg), .time_stamp(ts), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .start_out(start_out),
    .trip_out(trip_out), .blocked_out(blocked_out), .low_voltage_event_prefix_block(lvb),
    .evt_valid(evt_valid), .evt(evt), .irq(irq));

  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) begin
    if (evt_valid === 1'b1) evq.push_back(evt);
  end

  // ==========================================================
  // Bus and timing helpers
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // Returns two cycles after a tick, where that tick's outputs have settled
  task automatic wait_tick;
    int j;
    for (j = 0; j < 2 * TK; j++) begin
      @(posedge clk);
      if ((cyc - t0) % TK == 0) return;
    end
  endtask
  task automatic set_cfg(input int n, input logic [4:0] c, input int r, input int o);
    wr_reg(REG_CFG_BASE + 8'(4 * n), {27'h0, c});
    wr_reg(REG_REL_BASE + 8'(4 * n), 32'(r));
    wr_reg(REG_OPD_BASE + 8'(4 * n), 32'(o));
    wait_tick();
  endtask
  task automatic end_test;
    $display("test %s done", cur);
  endtask
  // Pick-up for three counted ticks, one tick of drop-out, then pick-up until trip
  task automatic run_case(input logic [4:0] c, output int n);
    set_cfg(0, c, 4, 6);
    want_pick[0] <= 1'b1;
    repeat (3) wait_tick();
    want_pick[0] <= 1'b0;
    wait_tick();
    want_pick[0] <= 1'b1;
    n = 0;
    while (n < 12) begin
      wait_tick();
      n++;
      if (trip_out[0] === 1'b1) break;
    end
    want_pick[0] <= 1'b0;
    repeat (2) wait_tick();
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    $display("wrong value at %0t in watchdog", $time);
    wrap_up();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < NUM_INST; i++) begin
      rd_reg(REG_CFG_BASE + 8'(4 * i), rv);
      `CHK(rv, {27'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1})
      rd_reg(REG_REL_BASE + 8'(4 * i), rv);
      `CHK(rv, 32'(60 / 5))
    end
    wr_reg(8'h04, 32'hFFFFFFFF);
    rd_reg(8'h04, rv);
    `CHK(rv, 32'h0)
    end_test();
    cur = "trip_timing";
    volt_in <= VW'($random(seed));
    ts <= $random(seed);
    fault_type <= FTW'($random(seed));
    sg <= SGW'($random(seed));
    opd = 1 + ($random(seed) & 3);
    set_cfg(0, 5'h1B, 12, opd);
    evq.delete();
    want_pick[0] <= 1'b1;
    for (k = 0; k < 3 * TK && start_out[0] !== 1'b1; k++) @(posedge clk);
    t0 = cyc;
    `CHK(trip_out[0], 1'b0)
    for (k = 1; k <= opd; k++) begin
      wait_tick();
      `CHK(trip_out[0], k == opd)
    end
    wait_tick();
    `CHK(evq.size(), 2)
    if (evq.size() == 2) begin
      `CHK({evq[0].inst, evq[0].kind, evq[0].rising}, {2'd0, KIND_START, 1'b1})
      `CHK({evq[0].stamp, evq[0].v_now}, {ts, volt_in})
      `CHK({evq[0].fault, evq[0].setting_group_index}, {fault_type, sg})
      `CHK(evq[1].kind, KIND_TRIP)
    end
    wr_reg(REG_REC_SEL, 32'h0);
    rd_reg(REG_REC_ID, rv);
    `CHK({rv[6:4], rv[3:2], rv[1:0]}, {sg, fault_type, KIND_START})
    rd_reg(REG_REC_STAMP, rv);
    `CHK(rv, ts)
    rd_reg(REG_REC_VOLT, rv);
    `CHK(rv[15:0], volt_in)
    evq.delete();
    want_pick[0] <= 1'b0;
    wait_tick();
    `CHK({start_out[0], trip_out[0]}, 2'b00)
    wait_tick();
    `CHK(evq.size(), 2)
    if (evq.size() == 2) begin
      `CHK({evq[0].kind, evq[0].rising, evq[1].kind}, {KIND_START, 1'b0, KIND_TRIP})
    end
    end_test();
    cur = "release";
    rel = 2 + ($random(seed) & 3);
    set_cfg(0, 5'h1B, rel, 100);
    want_pick[0] <= 1'b1;
    repeat (2) wait_tick();
    want_pick[0] <= 1'b0;
    for (k = 1; k <= rel + 1; k++) begin
      wait_tick();
      `CHK(start_out[0], k <= rel)
    end
    set_cfg(0, 5'h1A, rel, 100);
    want_pick[0] <= 1'b1;
    wait_tick();
    want_pick[0] <= 1'b0;
    for (k = 0; k <= rel; k++) begin
      wait_tick();
      `CHK(start_out[0], 1'b0)
    end
    end_test();
    cur = "timer_modes";
    run_case(5'h1B, n1);
    run_case(5'h19, n2);
    run_case(5'h1F, n3);
    `CHK(n2, n1 + 3)
    `CHK(n3, n1 - 1)
    set_cfg(0, 5'h1F, 4, 3);
    want_pick[0] <= 1'b1;
    repeat (3) wait_tick();
    want_pick[0] <= 1'b0;
    for (k = 0; k < 5; k++) begin
      wait_tick();
      `CHK(trip_out[0], 1'b0)
    end
    end_test();
    cur = "blocking";
    want_pick[2] <= 1'b1;
    repeat (2) wait_tick();
    evq.delete();
    want_block[2] <= 1'b1;
    wait_tick();
    `CHK(blocked_out[2], 1'b1)
    wait_tick();
    `CHK(evq.size() > 0, 1'b1)
    if (evq.size() > 0) begin
      `CHK({evq[0].inst, evq[0].kind, evq[0].rising}, {2'd2, KIND_BLOCK, 1'b1})
    end
    for (k = 0; k < 9; k++) begin
      wait_tick();
      `CHK(trip_out[2], 1'b0)
    end
    set_cfg(2, 5'h0B, 12, 8);
    evq.delete();
    want_pick[2] <= 1'b0;
    want_block[2] <= 1'b0;
    repeat (14) wait_tick();
    `CHK(evq.size(), 0)
    want_pick[2] <= 1'b1;
    want_block[2] <= 1'b1;
    wait_tick();
    `CHK({blocked_out[2], start_out[2]}, 2'b10)
    want_pick[2] <= 1'b0;
    want_block[2] <= 1'b0;
    end_test();
    cur = "low_voltage";
    set_cfg(3, 5'h1B, 12, 1);
    evq.delete();
    want_pick[3] <= 1'b1;
    want_lowv[3] <= 1'b1;
    repeat (3) wait_tick();
    `CHK({lvb[3], trip_out[3]}, 2'b10)
    nf = 0;
    foreach (evq[j]) if (evq[j].inst == 2'd3 && evq[j].kind == KIND_LOWV && evq[j].rising) nf++;
    `CHK(nf, 1)
    want_pick[3] <= 1'b0;
    want_lowv[3] <= 1'b0;
    end_test();
    cur = "interrupt";
    rd_reg(REG_IRQ_STAT, rv);
    `CHK({rv[6], rv[5:3], rv[1]}, 5'b10001)
    `CHK(irq, 1'b0)
    wr_reg(REG_IRQ_MASK, 32'h40);
    `CHK(irq, 1'b1)
    wr_reg(REG_IRQ_STAT, 32'h40);
    `CHK(irq, 1'b0)
    rd_reg(REG_IRQ_STAT, rv);
    `CHK(rv[6], 1'b0)
    end_test();
    cur = "record_roll";
    set_cfg(1, 5'h1A, 12, 100);
    for (i = 0; i < 13; i++) begin
      ts <= 32'(i);
      want_pick[1] <= 1'b1;
      wait_tick();
      want_pick[1] <= 1'b0;
      wait_tick();
    end
    wr_reg(REG_REC_SEL, 32'h10);
    rd_reg(REG_REC_INFO, rv);
    `CHK(rv[7:0], {4'd12, 4'd1})
    rd_reg(REG_REC_STAMP, rv);
    `CHK(rv, 32'd12)
    end_test();
    wrap_up();
  end
endmodule
`default_nettype wire
